//--- shared/lt_timer_map.svh
// Register offsets, field positions, reset values and timing counts of the lifetime timer
`ifndef LT_TIMER_MAP_SVH
`define LT_TIMER_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define LT_ADDR_W 12
`define LT_OFS_LOAD 12'h300
`define LT_OFS_VAL_LO 12'h304
`define LT_OFS_VAL_HI 12'h308
`define LT_OFS_CTRL 12'h30C
`define LT_OFS_CLEAR 12'h310
`define LT_OFS_CAPTURE 12'h314

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define LT_CTRL_RESET 32'h0000_0000
`define LT_CTRL_MASK 32'h0003_F7FF
`define LT_BIT_CAP_EN 17
`define LT_FLD_EVSEL_HI 16
`define LT_FLD_EVSEL_LO 12
`define LT_FLD_CLKSEL_HI 10
`define LT_FLD_CLKSEL_LO 9
`define LT_BIT_COUNT_UP 8
`define LT_BIT_ENABLE 7
`define LT_BIT_PERIODIC 6
`define LT_BIT_FMT_TOD 5
`define LT_BIT_FMT_H255 4
`define LT_BIT_MODE48 4
`define LT_FLD_PSC_HI 3
`define LT_FLD_PSC_LO 0

`define LT_CLK_OSC_INT 2'h0
`define LT_CLK_PERIPH 2'h1
`define LT_CLK_XTAL 2'h2
`define LT_CLK_CORE 2'h3

`define LT_PSC_DIV1 4'h0
`define LT_PSC_DIV16 4'h4
`define LT_PSC_DIV256 4'h8
`define LT_PSC_DIV32768 4'hF
`define LT_PSC_W 15
`define LT_PSC_LIM1 15'h0000
`define LT_PSC_LIM16 15'h000F
`define LT_PSC_LIM256 15'h00FF
`define LT_PSC_LIM32768 15'h7FFF

// ----------------------------------------------------------------------------
// Event select codes
// ----------------------------------------------------------------------------
`define LT_EV_N 18
`define LT_EV_LAST 5'h11
`define LT_EV_UNDEF 5'h07

// ----------------------------------------------------------------------------
// Time-of-day layout
// ----------------------------------------------------------------------------
`define LT_TOD_MASK 32'hFF3F_3F7F
`define LT_TOD_SUB_MAX 7'h7F
`define LT_TOD_MS_MAX 6'h3B
`define LT_TOD_H23 8'h17
`define LT_TOD_H255 8'hFF

// ----------------------------------------------------------------------------
// Bus answers and resets
// ----------------------------------------------------------------------------
`define LT_RESP_OKAY 2'h0
`define LT_RESP_SLVERR 2'h2
`define LT_LOAD_RESET 32'h0000_0000
`define LT_COUNT_RESET 48'h0000_0000_0000

`endif

//--- shared/lt_timer_pkg.sv
// Types shared by the lifetime timer
package lt_timer_pkg;
  typedef logic [47:0] lt_count_t;
  typedef enum logic [1:0] {LT_MODE_BIN16, LT_MODE_BIN48, LT_MODE_TOD} lt_mode_e;
endpackage

//--- design/lt_timer.sv
// Lifetime timer: 48-bit up, 16-bit up/down (with capture) or time-of-day counter, behind AXI4-Lite
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "lt_timer_map.svh"

module lt_timer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic osc32_int_in,
  input wire logic periph_clk_in,
  input wire logic xtal32_ext_in,
  input wire logic [`LT_EV_N-1:0] event_req,
  output logic timer_irq,
  input wire logic [`LT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`LT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [14:0] psc_limit(input logic [3:0] code);
    logic [14:0] r;
    unique case (code)
      `LT_PSC_DIV16: r = `LT_PSC_LIM16;
      `LT_PSC_DIV256: r = `LT_PSC_LIM256;
      `LT_PSC_DIV32768: r = `LT_PSC_LIM32768;
      default: r = `LT_PSC_LIM1;
    endcase
    return r;
  endfunction

  // One step of hours:minutes:seconds:1/128, up or down, hours wrap at hmax
  function automatic logic [31:0] tod_step(input logic [31:0] v, input logic up, input logic [7:0] hmax);
    logic [7:0] h;
    logic [5:0] m;
    logic [5:0] s;
    logic [6:0] f;
    h = v[31:24];
    m = v[21:16];
    s = v[13:8];
    f = v[6:0];
    if (up) begin
      f = f + 7'h01;
      if (f == 7'h00) begin
        s = (s == `LT_TOD_MS_MAX) ? 6'h00 : s + 6'h01;
        if (s == 6'h00) begin
          m = (m == `LT_TOD_MS_MAX) ? 6'h00 : m + 6'h01;
          if (m == 6'h00) begin
            h = (h == hmax) ? 8'h00 : h + 8'h01;
          end
        end
      end
    end else begin
      f = f - 7'h01;
      if (f == `LT_TOD_SUB_MAX) begin
        s = (s == 6'h00) ? `LT_TOD_MS_MAX : s - 6'h01;
        if (s == `LT_TOD_MS_MAX) begin
          m = (m == 6'h00) ? `LT_TOD_MS_MAX : m - 6'h01;
          if (m == `LT_TOD_MS_MAX) begin
            h = (h == 8'h00) ? hmax : h - 8'h01;
          end
        end
      end
    end
    return {h, 2'h0, m, 2'h0, s, 1'h0, f};
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] load_q;
  logic [15:0] cap_q;
  lt_timer_pkg::lt_count_t count_q;
  logic irq_q;
  logic [14:0] psc_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] lvl_q;
  logic [`LT_EV_N-1:0] ev_prev_q;
  logic aw_have_q;
  logic w_have_q;
  logic [`LT_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  // Format fields follow the word being written on the starting write, so the first value fits the new mode
  logic [31:0] ctrl_fmt;
  lt_timer_pkg::lt_mode_e mode;
  wire tod_sel = ctrl_fmt[`LT_BIT_FMT_TOD];
  assign mode = tod_sel ? lt_timer_pkg::LT_MODE_TOD :
                ctrl_fmt[`LT_BIT_MODE48] ? lt_timer_pkg::LT_MODE_BIN48 : lt_timer_pkg::LT_MODE_BIN16;
  wire [7:0] hmax = ctrl_fmt[`LT_BIT_FMT_H255] ? `LT_TOD_H255 : `LT_TOD_H23;
  wire count_up = (mode == lt_timer_pkg::LT_MODE_BIN48) | ctrl_fmt[`LT_BIT_COUNT_UP];
  wire periodic = ctrl_fmt[`LT_BIT_PERIODIC];
  wire enabled = ctrl_q[`LT_BIT_ENABLE];
  wire [1:0] clk_sel = ctrl_q[`LT_FLD_CLKSEL_HI:`LT_FLD_CLKSEL_LO];
  wire [4:0] ev_sel = ctrl_q[`LT_FLD_EVSEL_HI:`LT_FLD_EVSEL_LO];

  lt_timer_pkg::lt_count_t full_scale;
  assign full_scale = (mode == lt_timer_pkg::LT_MODE_BIN48) ? {48{1'b1}} :
                      (mode == lt_timer_pkg::LT_MODE_TOD) ?
                      {16'h0000, hmax, 2'h0, `LT_TOD_MS_MAX, 2'h0, `LT_TOD_MS_MAX, 1'h0, `LT_TOD_SUB_MAX} :
                      {32'h0000_0000, 16'hFFFF};
  lt_timer_pkg::lt_count_t terminal;
  assign terminal = count_up ? full_scale : `LT_COUNT_RESET;
  lt_timer_pkg::lt_count_t load_ext;
  assign load_ext = (mode == lt_timer_pkg::LT_MODE_TOD) ? {16'h0000, load_q & `LT_TOD_MASK} :
                    {32'h0000_0000, load_q[15:0]};
  lt_timer_pkg::lt_count_t free_start;
  assign free_start = count_up ? `LT_COUNT_RESET : full_scale;
  lt_timer_pkg::lt_count_t restart;
  assign restart = periodic ? load_ext : free_start;

  lt_timer_pkg::lt_count_t step_val;
  assign step_val = (mode == lt_timer_pkg::LT_MODE_TOD) ? {16'h0000, tod_step(count_q[31:0], count_up, hmax)} :
                    (mode == lt_timer_pkg::LT_MODE_BIN48) ? count_q + 48'h1 :
                    {32'h0000_0000, count_up ? count_q[15:0] + 16'h1 : count_q[15:0] - 16'h1};
  wire at_term = (count_q == terminal);

  // --------------------------------------------------------------------------
  // Clock source and prescaler
  // --------------------------------------------------------------------------
  // Pin clocks are sampled, so they must stay well below half of clk_sys
  wire [2:0] agree = ~(sync2_q ^ sync3_q);
  wire [2:0] rise = agree & sync3_q & ~lvl_q;
  logic src_edge;
  assign src_edge = (clk_sel == `LT_CLK_CORE) ? 1'b1 :
                    (clk_sel == `LT_CLK_PERIPH) ? rise[1] :
                    (clk_sel == `LT_CLK_XTAL) ? rise[2] : rise[0];
  wire [14:0] lim = psc_limit(ctrl_q[`LT_FLD_PSC_HI:`LT_FLD_PSC_LO]);
  wire tick = src_edge & (psc_q == lim) & enabled;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire aw_now = aw_have_q | aw_take;
  wire w_now = w_have_q | w_take;
  wire wr_fire = aw_now & w_now & ~bvalid_q;
  wire [`LT_ADDR_W-1:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
  wire wr_load = wr_fire & (wa == `LT_OFS_LOAD);
  wire wr_ctrl = wr_fire & (wa == `LT_OFS_CTRL);
  wire wr_clear = wr_fire & (wa == `LT_OFS_CLEAR);
  wire wr_ro = wr_fire & ((wa == `LT_OFS_VAL_LO) | (wa == `LT_OFS_VAL_HI) | (wa == `LT_OFS_CAPTURE));
  wire wr_ok = wr_load | wr_ctrl | wr_clear | wr_ro;
  wire [31:0] ctrl_new = merge_strb(ctrl_q, wd, ws) & `LT_CTRL_MASK;
  wire start = wr_ctrl & ctrl_new[`LT_BIT_ENABLE] & ~enabled;
  assign ctrl_fmt = start ? ctrl_new : ctrl_q;

  wire ar_take = s_axi_arvalid & arready_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  assign rd_hit = (s_axi_araddr == `LT_OFS_LOAD) | (s_axi_araddr == `LT_OFS_VAL_LO) |
                  (s_axi_araddr == `LT_OFS_VAL_HI) | (s_axi_araddr == `LT_OFS_CTRL) |
                  (s_axi_araddr == `LT_OFS_CLEAR) | (s_axi_araddr == `LT_OFS_CAPTURE);
  assign rd_mux = (s_axi_araddr == `LT_OFS_LOAD) ? load_ext[31:0] :
                  (s_axi_araddr == `LT_OFS_VAL_LO) ?
                  ((mode == lt_timer_pkg::LT_MODE_TOD) ? count_q[31:0] : {16'h0000, count_q[15:0]}) :
                  (s_axi_araddr == `LT_OFS_VAL_HI) ?
                  ((mode == lt_timer_pkg::LT_MODE_BIN48) ? count_q[47:16] : 32'h0000_0000) :
                  (s_axi_araddr == `LT_OFS_CTRL) ? ctrl_q :
                  (s_axi_araddr == `LT_OFS_CAPTURE) ? {16'h0000, cap_q} : 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Capture trigger
  // --------------------------------------------------------------------------
  wire ev_valid = (ev_sel <= `LT_EV_LAST) & (ev_sel != `LT_EV_UNDEF);
  wire ev_cur = ev_valid & event_req[ev_sel];
  wire ev_old = ev_valid & ev_prev_q[ev_sel];
  wire cap_fire = ctrl_q[`LT_BIT_CAP_EN] & (mode == lt_timer_pkg::LT_MODE_BIN16) & ev_cur & ~ev_old;

  // --------------------------------------------------------------------------
  // Counter, prescaler, interrupt
  // --------------------------------------------------------------------------
  logic irq_set;
  assign irq_set = tick & ~at_term & (step_val == terminal);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      lvl_q <= 3'h0;
      ev_prev_q <= '0;
    end else begin
      sync1_q <= {xtal32_ext_in, periph_clk_in, osc32_int_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= (agree & sync3_q) | (~agree & lvl_q);
      ev_prev_q <= event_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      psc_q <= 15'h0000;
    end else if (start | wr_clear | ~enabled) begin
      psc_q <= 15'h0000;
    end else if (src_edge) begin
      psc_q <= (psc_q == lim) ? 15'h0000 : psc_q + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_q <= `LT_COUNT_RESET;
    end else if (wr_clear) begin
      count_q <= load_ext;
    end else if (start) begin
      count_q <= restart;
    end else if (tick) begin
      count_q <= at_term ? restart : step_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (wr_clear) begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q <= `LT_CTRL_RESET;
      load_q <= `LT_LOAD_RESET;
      cap_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_new;
      end
      if (wr_load) begin
        load_q <= merge_strb(load_q, wd, ws);
      end
      if (cap_fire) begin
        cap_q <= count_q[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `LT_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_have_q <= aw_now & ~wr_fire;
      w_have_q <= w_now & ~wr_fire;
      awready_q <= ~aw_now & ~wr_fire & ~(bvalid_q & ~s_axi_bready) | (bvalid_q & s_axi_bready);
      wready_q <= ~w_now & ~wr_fire & ~(bvalid_q & ~s_axi_bready) | (bvalid_q & s_axi_bready);
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `LT_RESP_OKAY : `LT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `LT_RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? `LT_RESP_OKAY : `LT_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign timer_irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_irq_on_reach: assert property (@(posedge clk_sys) disable iff (!nrst) irq_set |=> timer_irq)
    else $error("interrupt not raised on reaching terminal count");
  a_clear_drops_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear && !irq_set |=> !timer_irq)
    else $error("clear write left interrupt pending");
  a_clear_reloads: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clear |=> count_q == $past(load_ext))
    else $error("clear write did not reload counter");
  a_hold_disabled: assert property (@(posedge clk_sys) disable iff (!nrst)
    !enabled && !wr_clear && !wr_ctrl |=> $stable(count_q))
    else $error("counter moved while disabled");
  a_step_by_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick && !at_term && !wr_clear && !start && mode == lt_timer_pkg::LT_MODE_BIN16 && count_up
    |=> count_q[15:0] == $past(count_q[15:0]) + 16'h1)
    else $error("16-bit up count did not advance by one");
  a_wrap_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick && at_term && !periodic && !wr_clear |=> count_q == $past(free_start))
    else $error("free-running wrap restarted at wrong value");
  a_capture_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    cap_fire |=> cap_q == $past(count_q[15:0]))
    else $error("capture register missed running count");
  a_capture_once: assert property (@(posedge clk_sys) disable iff (!nrst)
    cap_fire |=> !cap_fire)
    else $error("capture fired twice on one assertion");
  a_write_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  // Cycles since the last tick; a control or clear write restarts the spacing
  logic [7:0] tick_gap_q;
  logic tick_seen_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst || wr_ctrl || wr_clear) begin
      tick_gap_q <= 8'h00;
      tick_seen_q <= 1'b0;
    end else if (tick) begin
      tick_gap_q <= 8'h00;
      tick_seen_q <= 1'b1;
    end else if (tick_gap_q != 8'hFF) begin
      tick_gap_q <= tick_gap_q + 8'h01;
    end
  end
  a_psc_div16: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick && tick_seen_q && clk_sel == `LT_CLK_CORE && ctrl_q[`LT_FLD_PSC_HI:`LT_FLD_PSC_LO] == `LT_PSC_DIV16
    |-> tick_gap_q == 8'h0F)
    else $error("divide-by-16 tick spacing wrong");

endmodule

//--- tb/lt_timer_tb_top.sv
// Self-checking testbench of the lifetime timer
`timescale 1ns/1ns
`include "lt_timer_map.svh"

module lt_timer_tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] slow_q = 5'h00;
  logic [`LT_EV_N-1:0] event_req = '0;
  logic timer_irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // ----------------------------------------------------------------------------
  // Clock, slow sources and watchdog
  // ----------------------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  // Three different slow rates so a wrong source pick shows as a wrong step count
  always @(posedge clk_sys) slow_q <= slow_q + 5'h01;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      summarize();
    end
  end

  lt_timer DUT (.clk_sys(clk_sys), .nrst(nrst), .osc32_int_in(slow_q[3]), .periph_clk_in(slow_q[2]),
    .xtal32_ext_in(slow_q[4]), .event_req(event_req), .timer_irq(timer_irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    // Let an edge pass so back-to-back calls never drive one strobe twice in a step
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!ar_done && s_axi_arready) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(r, `LT_RESP_OKAY, "write response");
  endtask

  task automatic rd_ok(input logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    check(r, `LT_RESP_OKAY, "read response");
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_ok(`LT_OFS_CTRL, d); check(d, `LT_CTRL_RESET, "control reset");
    rd_ok(`LT_OFS_VAL_LO, d); check(d, 32'h0, "low word reset");
    rd_ok(`LT_OFS_VAL_HI, d); check(d, 32'h0, "high word reset");
    rd_ok(`LT_OFS_CAPTURE, d); check(d, 32'h0, "capture reset");
    wr_ok(`LT_OFS_LOAD, 32'h0000_1234);
    rd_ok(`LT_OFS_LOAD, d); check(d, 32'h0000_1234, "load readback");
    wr_ok(`LT_OFS_VAL_LO, 32'h0000_AAAA);
    rd_ok(`LT_OFS_VAL_LO, d); check(d, 32'h0, "low word ignores writes");
    wr_ok(`LT_OFS_VAL_HI, 32'h5555_AAAA);
    rd_ok(`LT_OFS_VAL_HI, d); check(d, 32'h0, "high word ignores writes");
    wr(12'h3F0, 32'h1, r); check(r, `LT_RESP_SLVERR, "unmapped write");
    rd(12'h3F0, d, r); check(r, `LT_RESP_SLVERR, "unmapped read");
    wr_ok(`LT_OFS_CTRL, 32'h0000_0028);
    wr_ok(`LT_OFS_LOAD, 32'hFFFF_FFFF);
    rd_ok(`LT_OFS_LOAD, d); check(d, `LT_TOD_MASK, "time-of-day load layout");
    wr_ok(`LT_OFS_CTRL, 32'h0);
    $display("test registers done");
  endtask

  task automatic test_tod();
    logic [31:0] d;
    wr_ok(`LT_OFS_LOAD, 32'h003B_3B7E);
    wr_ok(`LT_OFS_CTRL, 32'h0000_07E0);
    rd_ok(`LT_OFS_VAL_LO, d);
    check(d >= 32'h0100_0000 && d <= 32'h0100_0003, 1'b1, "time-of-day carries into hours");
    wr_ok(`LT_OFS_CTRL, 32'h0000_0000);
    $display("test time of day done");
  endtask

  task automatic test_periodic();
    logic [31:0] d;
    wr_ok(`LT_OFS_LOAD, 32'd40);
    wr_ok(`LT_OFS_CTRL, 32'h0000_06C0);
    check(timer_irq, 1'b0, "no interrupt before terminal count");
    while (timer_irq !== 1'b1) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    check(timer_irq, 1'b1, "interrupt holds until cleared");
    rd_ok(`LT_OFS_VAL_LO, d); check(d <= 32'd40, 1'b1, "periodic restarts from load");
    wr_ok(`LT_OFS_CLEAR, 32'h0000_00A5);
    @(posedge clk_sys);
    check(timer_irq, 1'b0, "clear drops interrupt");
    rd_ok(`LT_OFS_VAL_LO, d); check(d >= 32'd33 && d <= 32'd40, 1'b1, "clear reloads");
    wr_ok(`LT_OFS_CTRL, 32'h0000_0640);
    rd_ok(`LT_OFS_VAL_LO, d);
    repeat (20) @(posedge clk_sys);
    check(timer_irq, 1'b0, "no interrupt while disabled");
    begin
      logic [31:0] e;
      rd_ok(`LT_OFS_VAL_LO, e); check(e, d, "disabled counter holds");
    end
    wr_ok(`LT_OFS_CLEAR, 32'h0);
    $display("test periodic done");
  endtask

  task automatic test_free_up();
    logic [31:0] d;
    wr_ok(`LT_OFS_CTRL, 32'h0000_0780);
    while (timer_irq !== 1'b1) @(posedge clk_sys);
    rd_ok(`LT_OFS_VAL_LO, d); check(d < 32'h10, 1'b1, "free run restarts at zero");
    wr_ok(`LT_OFS_CTRL, 32'h0);
    wr_ok(`LT_OFS_CLEAR, 32'h0);
    $display("test free running done");
  endtask

  task automatic test_wide();
    logic [31:0] d, e;
    wr_ok(`LT_OFS_CTRL, 32'h0000_0690);
    rd_ok(`LT_OFS_VAL_LO, d); check(d < 32'h10, 1'b1, "wide count starts at zero");
    repeat (100) @(posedge clk_sys);
    rd_ok(`LT_OFS_VAL_LO, e); check(e - d >= 32'd100 && e - d <= 32'd106, 1'b1, "wide counts up");
    rd_ok(`LT_OFS_VAL_HI, d); check(d, 32'h0, "high word of small count");
    wr_ok(`LT_OFS_CTRL, 32'h0);
    $display("test wide done");
  endtask

  task automatic test_rates();
    logic [31:0] ctl [6] = '{32'h680, 32'h684, 32'h688, 32'h080, 32'h280, 32'h480};
    int wt [6] = '{100, 320, 2560, 320, 320, 320};
    int lo [6] = '{102, 19, 9, 18, 38, 8};
    int hi [6] = '{104, 21, 11, 22, 42, 12};
    logic [31:0] d, e;
    logic [15:0] df;
    for (int i = 0; i < 6; i++) begin
      wr_ok(`LT_OFS_CTRL, ctl[i]);
      rd_ok(`LT_OFS_VAL_LO, d);
      repeat (wt[i]) @(posedge clk_sys);
      rd_ok(`LT_OFS_VAL_LO, e);
      df = d[15:0] - e[15:0];
      check(df >= lo[i] && df <= hi[i], 1'b1, "step count of prescale or source");
      wr_ok(`LT_OFS_CTRL, 32'h0);
    end
    $display("test rates done");
  endtask

  task automatic test_capture();
    logic [4:0] codes [3] = '{5'h00, 5'h03, `LT_EV_LAST};
    logic [31:0] p, d;
    for (int i = 0; i < 3; i++) begin
      rd_ok(`LT_OFS_CAPTURE, p);
      wr_ok(`LT_OFS_CTRL, 32'h0002_0680 | (32'(codes[i]) << 12));
      event_req[(codes[i] + 1) % `LT_EV_N] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_ok(`LT_OFS_CAPTURE, d); check(d, p, "other source does not capture");
      repeat (3 * i) @(posedge clk_sys);
      event_req[codes[i]] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_ok(`LT_OFS_CAPTURE, d); check(d != p && d > 32'hFF00 && d <= 32'hFFFF, 1'b1, "capture taken");
      repeat (20) @(posedge clk_sys);
      rd_ok(`LT_OFS_CAPTURE, p); check(p, d, "held request captures once");
      event_req <= '0;
      wr_ok(`LT_OFS_CTRL, 32'h0);
    end
    $display("test capture done");
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_tod();
    test_periodic();
    test_free_up();
    test_wide();
    test_rates();
    test_capture();
    summarize();
  end
endmodule
